// [lpm_pkg.sv]
// Package for the low-power mode and wake-up controller
package lpm_pkg;

  // ==========================================
  // Mode states
  typedef enum logic [3:0] {
    ST_RUN   = 4'b0001,
    ST_IDLE  = 4'b0010,
    ST_PDOWN = 4'b0100,
    ST_WAKE  = 4'b1000
  } lpm_state_t;

  // ==========================================
  // Wake cause flags
  typedef struct packed {
    logic rx;
    logic irq_one;
    logic irq_zero;
  } wake_cause_t;

  // ==========================================
  // Wake enables from interrupt enable and card uart control two
  typedef struct packed {
    logic global_en;
    logic irq_zero_en;
    logic irq_one_en;
    logic serial_en;
    logic line_one_wake_en;
    logic receive_wake_en;
  } wake_enable_t;

  // ==========================================
  // Port pin view
  typedef struct packed {
    logic [7:0] p0_out;
    logic       p0_oe;
    logic [7:0] p1_out;
    logic [7:0] p2_out;
    logic [7:0] p3_out;
  } port_pins_t;

  // ==========================================
  // Constants
  localparam int          OSC_RESTART_CYCLES = 1024;
  localparam int          DELAY_W            = 11;
  localparam logic [10:0] DELAY_LOAD         = 11'h400;
  localparam logic        STROBE_IDLE        = 1'b1;
  localparam logic        STROBE_PDOWN       = 1'b0;
  localparam logic [1:0]  RESET_SYNC         = 2'h0;
  localparam logic [7:0]  PORT_RESET         = 8'hff;

endpackage

// [lpm_ctrl.sv]
// Low-power mode control and wake-up logic for the embedded core
`timescale 1ns/100ps
// What this block does
// - Core clock may stop; state retained
// - Idle halts core, peripherals keep running
// - Idle exits on enabled interrupt or reset
// - Power-down stops oscillator after requesting instruction
// - Power-down exits: reset, external irq, receive
// - Reset-wake keeps RAM; irq-wake keeps all
// - Delay counter holds internal irq lines low
// - Resume after instruction entering power-down
// - Idle: strobes high, port 0 floats if external
// - Internal clock is oscillator divided by two
module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter int DELAY_CYCLES = OSC_RESTART_CYCLES
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Mode requests from power control bits
  input  wire logic         idle_req,
  input  wire logic         pdown_req,
  input  wire logic         ext_program_mem,
  // Wake sources and enables
  input  wire logic         ext_irq_zero_n,
  input  wire logic         ext_irq_one_n,
  input  wire logic         rx_in,
  input  wire wake_enable_t wake_en,
  input  wire logic         any_irq_pending,
  // Core-side state for the pins
  input  wire port_pins_t   port_run,
  input  wire logic [7:0]   p2_addr_hi,
  input  wire logic         ale_run,
  input  wire logic         program_store_strobe_run_n,
  // Outputs
  output logic              core_clk_en,
  output logic              periph_clk_en,
  output logic              osc_enable,
  output logic              idle_bit_clr,
  output logic              pdown_bit_clr,
  output logic              int_irq_zero_n,
  output logic              int_irq_one_n,
  output wake_cause_t       wake_cause,
  output logic              ale,
  output logic              program_store_strobe_n,
  output port_pins_t        port_pins,
  output lpm_state_t        mode_state
);

  // ==========================================
  // Reset release
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_r <= RESET_SYNC;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ==========================================
  // Input edge detection
  logic rx_d_r, i0_d_r, i1_d_r;
  logic rx_d_nxt, i0_d_nxt, i1_d_nxt;
  logic rx_fall, i0_fall, i1_fall;

  always_comb begin
    rx_d_nxt = rx_in;
    i0_d_nxt = ext_irq_zero_n;
    i1_d_nxt = ext_irq_one_n;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_d_r <= 1'b1;
      i0_d_r <= 1'b1;
      i1_d_r <= 1'b1;
    end else begin
      rx_d_r <= rx_d_nxt;
      i0_d_r <= i0_d_nxt;
      i1_d_r <= i1_d_nxt;
    end
  end

  assign rx_fall = rx_d_r & ~rx_in;
  assign i0_fall = i0_d_r & ~ext_irq_zero_n;
  assign i1_fall = i1_d_r & ~ext_irq_one_n;

  // ==========================================
  // Wake qualification
  logic wake0, wake1, wake_rx, wake_any;

  assign wake0 = i0_fall & wake_en.global_en & wake_en.irq_zero_en;
  assign wake1 = i1_fall & wake_en.global_en & wake_en.irq_one_en
                 & wake_en.line_one_wake_en;
  assign wake_rx = rx_fall & wake_en.global_en & wake_en.line_one_wake_en
                   & wake_en.receive_wake_en;
  assign wake_any = wake0 | wake1 | wake_rx;

  // ==========================================
  // Mode state machine and delay counter
  lpm_state_t           state_r, state_nxt;
  logic [DELAY_W-1:0]   dly_r, dly_nxt;
  wake_cause_t          cause_r, cause_nxt;
  logic                 idle_clr_nxt, pd_clr_nxt;
  logic                 idle_clr_r, pd_clr_r;

  always_comb begin
    state_nxt    = state_r;
    dly_nxt      = dly_r;
    cause_nxt    = cause_r;
    idle_clr_nxt = 1'b0;
    pd_clr_nxt   = 1'b0;
    case (state_r)
      ST_RUN: begin
        if (pdown_req) begin
          state_nxt = ST_PDOWN;
        end else if (idle_req) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (any_irq_pending) begin
          state_nxt    = ST_RUN;
          idle_clr_nxt = 1'b1;
        end
      end
      ST_PDOWN: begin
        if (wake_any) begin
          state_nxt = ST_WAKE;
          dly_nxt   = DELAY_W'(DELAY_CYCLES - 1);
          // cause kept for firmware to read
          cause_nxt = cause_r | wake_cause_t'{rx: wake_rx, irq_one: wake1, irq_zero: wake0};
        end
      end
      ST_WAKE: begin
        if (dly_r == '0) begin
          // back to run, core resumes in place
          state_nxt  = ST_RUN;
          pd_clr_nxt = 1'b1;
        end else begin
          dly_nxt = dly_r - 1'b1;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
    // Cause clears on the next power-down request from run; a new wake would reload it
    if (state_r == ST_RUN && pdown_req) begin
      cause_nxt = '0;
    end
  end

  // reset reinitialises mode logic only; RAM lives elsewhere
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= ST_RUN;
      dly_r      <= '0;
      cause_r    <= '0;
      idle_clr_r <= 1'b0;
      pd_clr_r   <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      dly_r      <= dly_nxt;
      cause_r    <= cause_nxt;
      idle_clr_r <= idle_clr_nxt;
      pd_clr_r   <= pd_clr_nxt;
    end
  end

  // ==========================================
  // Divide-by-two and clock enables
  logic div_r, div_nxt;
  logic core_en_nxt, per_en_nxt, osc_nxt;
  logic ale_nxt, pss_nxt, i0n_nxt, i1n_nxt;
  port_pins_t pins_nxt;

  always_comb begin
    div_nxt = (state_r == ST_PDOWN) ? div_r : ~div_r;
  end

  always_comb begin
    // clock may stop, state held by enable
    core_en_nxt = div_nxt & (state_nxt == ST_RUN);
    per_en_nxt  = div_nxt & (state_nxt != ST_PDOWN) & (state_nxt != ST_WAKE);
    osc_nxt     = (state_nxt != ST_PDOWN);
    // internal lines held low during restart
    i0n_nxt = ext_irq_zero_n;
    i1n_nxt = ext_irq_one_n;
    if (state_nxt == ST_WAKE) begin
      i0n_nxt = 1'b0;
      i1n_nxt = 1'b0;
    end
    ale_nxt  = ale_run;
    pss_nxt  = program_store_strobe_run_n;
    pins_nxt = port_run;
    case (state_nxt)
      ST_IDLE: begin
        ale_nxt = STROBE_IDLE;
        pss_nxt = STROBE_IDLE;
        if (ext_program_mem) begin
          pins_nxt.p0_oe  = 1'b0;
          pins_nxt.p2_out = p2_addr_hi;
        end
      end
      ST_PDOWN, ST_WAKE: begin
        ale_nxt = STROBE_PDOWN;
        pss_nxt = STROBE_PDOWN;
        if (ext_program_mem) begin
          pins_nxt.p0_oe = 1'b0;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r                  <= 1'b0;
      core_clk_en            <= 1'b0;
      periph_clk_en          <= 1'b0;
      osc_enable             <= 1'b1;
      int_irq_zero_n         <= 1'b1;
      int_irq_one_n          <= 1'b1;
      ale                    <= 1'b1;
      program_store_strobe_n <= 1'b1;
      port_pins              <= '{p0_out: PORT_RESET, p0_oe: 1'b0, p1_out: PORT_RESET,
                                  p2_out: PORT_RESET, p3_out: PORT_RESET};
    end else begin
      div_r                  <= div_nxt;
      core_clk_en            <= core_en_nxt;
      periph_clk_en          <= per_en_nxt;
      osc_enable             <= osc_nxt;
      int_irq_zero_n         <= i0n_nxt;
      int_irq_one_n          <= i1n_nxt;
      ale                    <= ale_nxt;
      program_store_strobe_n <= pss_nxt;
      port_pins              <= pins_nxt;
    end
  end

  // mode bit clear pulses on exit
  assign idle_bit_clr  = idle_clr_r;
  assign pdown_bit_clr = pd_clr_r;
  assign wake_cause    = cause_r;
  assign mode_state    = state_r;

endmodule

// [lpm_ctrl_monitor.sv]
// Port assertions for the low-power mode controller
`timescale 1ns/100ps
module lpm_ctrl_monitor
  import lpm_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // Watched ports
  input wire logic       ext_program_mem,
  input wire logic [7:0] p2_addr_hi,
  input wire logic       core_clk_en,
  input wire logic       osc_enable,
  input wire logic       pdown_bit_clr,
  input wire logic       int_irq_zero_n,
  input wire logic       int_irq_one_n,
  input wire logic       ale,
  input wire logic       program_store_strobe_n,
  input wire port_pins_t port_pins,
  input wire lpm_state_t mode_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================
  // Wake steps
  sequence wake_entry_s;
    mode_state == ST_PDOWN ##1 mode_state == ST_WAKE;
  endsequence
  sequence wake_hold_s;
    (!int_irq_zero_n && !int_irq_one_n)[*3];
  endsequence
  sequence wake_done_s;
    mode_state == ST_WAKE ##1 mode_state == ST_RUN;
  endsequence
  pd_strobes_a: assert property (
    mode_state == ST_PDOWN |-> !ale && !program_store_strobe_n) else $error("strobes high");
  pd_float_a: assert property (
    mode_state == ST_PDOWN && ext_program_mem |-> !port_pins.p0_oe) else $error("port 0 drives");
  idle_strobes_a: assert property (
    mode_state == ST_IDLE |-> ale && program_store_strobe_n) else $error("strobes low");
  idle_ports_a: assert property (
    mode_state == ST_IDLE && ext_program_mem |-> !port_pins.p0_oe
    && port_pins.p2_out == p2_addr_hi) else $error("idle port view wrong");
  pd_osc_a: assert property (
    mode_state == ST_PDOWN |-> !osc_enable) else $error("oscillator runs");
  idle_halt_a: assert property (
    mode_state == ST_IDLE |-> !core_clk_en) else $error("core runs in idle");
  clk_div_a: assert property (
    mode_state == ST_RUN && core_clk_en |=> !core_clk_en) else $error("no divide by two");
  wake_src_a: assert property (
    $rose(mode_state == ST_WAKE) |-> $past(mode_state) == ST_PDOWN) else $error("bad wake");
  wake_hold_a: assert property (
    wake_entry_s |-> wake_hold_s) else $error("irq lines not held low");
  bit_clr_a: assert property (
    wake_done_s |-> pdown_bit_clr ##1 !pdown_bit_clr) else $error("no clear pulse");
endmodule

// [lpm_wake_src.sv]
// Wake source model: interrupt pins and serial receive line
`timescale 1ns/100ps
module lpm_wake_src (
  // Clock and command
  input  wire logic       clk,
  input  wire logic [2:0] fire,
  // Pins, pulled up while idle
  output logic            ext_irq_zero_n = 1'b1,
  output logic            ext_irq_one_n  = 1'b1,
  output logic            rx_in          = 1'b1
);
  // single falling edge
  // A short low only: the controller must stretch it itself
  always @(posedge clk) begin
    {rx_in, ext_irq_one_n, ext_irq_zero_n} <= ~fire;
  end
endmodule

// [cpu_low_power_mode_wakeup_bench.sv]
// Self-checking bench for the low-power mode controller
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; $display("BAD %0t mismatch", $time); end end
module cpu_low_power_mode_wakeup_bench
  import lpm_pkg::*;
;
  logic         clk = 1'b0, resetn = 1'b0, idle_req = 1'b0, pdown_req = 1'b0;
  logic         ext_program_mem = 1'b0, any_irq_pending = 1'b0;
  logic         core_clk_en, periph_clk_en, osc_enable, idle_bit_clr, pdown_bit_clr, ale;
  logic         ext_irq_zero_n, ext_irq_one_n, rx_in, int_irq_zero_n, int_irq_one_n;
  logic         program_store_strobe_n;
  logic [2:0]   fire = 3'h0;
  wake_enable_t wake_en = 6'h00;
  wake_cause_t  wake_cause;
  port_pins_t   port_pins;
  lpm_state_t   mode_state;
  int           err_total = 0, cmp_count = 0;
  // ==========================================
  // Design and far side
  lpm_ctrl #(.DELAY_CYCLES(4)) uut (.clk, .resetn, .idle_req, .pdown_req, .ext_program_mem,
    .ext_irq_zero_n, .ext_irq_one_n, .rx_in, .wake_en, .any_irq_pending,
    .port_run(33'h1a5c3b2d1), .p2_addr_hi(8'h5c), .ale_run(1'b1),
    .program_store_strobe_run_n(1'b1), .core_clk_en, .periph_clk_en, .osc_enable,
    .idle_bit_clr, .pdown_bit_clr, .int_irq_zero_n, .int_irq_one_n, .wake_cause, .ale,
    .program_store_strobe_n, .port_pins, .mode_state);
  lpm_wake_src src (.clk, .fire, .ext_irq_zero_n, .ext_irq_one_n, .rx_in);
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic final_report;
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_st(input lpm_state_t s);
    int n;
    n = 0;
    while (mode_state !== s && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (mode_state !== s) begin
      err_total++;
      $display("BAD %0t timeout", $time);
      final_report();
    end
  endtask
  task automatic pulse(input int sel);
    fire = 3'h1 << sel;
    repeat (2) @(negedge clk);
    fire = 3'h0;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_idle;
    int k, n;
    ext_program_mem = 1'b1;
    idle_req = 1'b1;
    wait_st(ST_IDLE);
    idle_req = 1'b0;
    `CHK({ale, program_store_strobe_n, port_pins.p0_oe}, 3'b110)
    `CHK(port_pins.p2_out, 8'h5c)
    // Peripheral enable must keep pulsing every second cycle
    n = 0;
    for (k = 0; k < 10; k++) begin
      @(negedge clk);
      n += int'(periph_clk_en);
    end
    `CHK(n, 5)
    `CHK(mode_state, ST_IDLE)
    any_irq_pending = 1'b1;
    wait_st(ST_RUN);
    any_irq_pending = 1'b0;
    `CHK(idle_bit_clr, 1'b1)
    ext_program_mem = 1'b0;
  endtask
  task automatic t_pdown(input int sel, input logic [5:0] en, input logic refuse);
    logic c;
    wake_en = en;
    pdown_req = 1'b1;
    wait_st(ST_PDOWN);
    pdown_req = 1'b0;
    `CHK(osc_enable, 1'b0)
    `CHK({ale, program_store_strobe_n}, 2'b00)
    `CHK(port_pins, 33'h1a5c3b2d1)
    pulse(sel);
    if (refuse) begin
      repeat (20) @(negedge clk);
      `CHK(mode_state, ST_PDOWN)
      sel = 0;
      pulse(0);
    end
    wait_st(ST_WAKE);
    `CHK({int_irq_zero_n, int_irq_one_n}, 2'b00)
    wait_st(ST_RUN);
    `CHK(wake_cause, 3'h1 << sel)
    `CHK(pdown_bit_clr, 1'b1)
    c = core_clk_en;
    @(negedge clk);
    `CHK(c ^ core_clk_en, 1'b1)
    // Cause must still stand for the service routine to read
    `CHK(wake_cause, 3'h1 << sel)
  endtask
  task automatic t_reset;
    ext_program_mem = 1'b1;
    pdown_req = 1'b1;
    wait_st(ST_PDOWN);
    pdown_req = 1'b0;
    `CHK(port_pins.p0_oe, 1'b0)
    `CHK(port_pins.p2_out, 8'hb2)
    resetn = 1'b0;
    @(negedge clk);
    `CHK({mode_state, osc_enable}, {ST_RUN, 1'b1})
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    ext_program_mem = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    t_idle;
    t_pdown(0, 6'h3f, 1'b0);
    t_pdown(1, 6'h3f, 1'b0);
    t_pdown(2, 6'h3f, 1'b0);
    t_pdown(1, 6'h3d, 1'b1);
    t_pdown(2, 6'h3e, 1'b1);
    t_reset;
    final_report();
  end
endmodule
bind lpm_ctrl lpm_ctrl_monitor mon (.clk, .resetn, .ext_program_mem, .p2_addr_hi, .core_clk_en,
  .osc_enable, .pdown_bit_clr, .int_irq_zero_n, .int_irq_one_n, .ale, .program_store_strobe_n,
  .port_pins, .mode_state);
